// ===== verilog/arsel_top.sv
// Converter result formatting and channel/reference selection block.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Finished conversion result is readable through low and high result bytes.
// - Single-ended result is unsigned 10-bit, 0 is ground, all ones top.
// - Unipolar differential result is 0..1023, forced to zero when negative.
// - Differential pairs get gain 8x or 20x chosen by the channel field.
// - Unipolar by default; bipolar select bit one switches to bipolar.
// - Bipolar result scales by 512 and is 10-bit two's complement.
// - Bipolar result bit nine is the sign, one meaning negative.
// - Gain calibration 8-bit in 1/128 units and signed offset are held.
// - Reference pin driven only when converter on and output enabled.
// - Reference bits with external enable decode the reference source.
// - Reference change during conversion applies after it completes.
// - After any change of the reference bits the next conversion takes 25 cycles.
// - Left adjust bit realigns the result registers immediately.
// - Channel field change during conversion applies after it completes.
// - Selection bits held in a temporary register, copied at safe points.
// - Done flag is set when conversion finishes and results update.
module arsel_top #(
	parameter logic [7:0] GAIN_CAL   = 8'h80, // Arbitrary value.
	parameter logic [7:0] OFFSET_CAL = 8'h00, // Arbitrary value.
	parameter int         CODE_W     = 11
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        converter_on,
	input  wire logic        conv_start,
	input  wire logic        core_done,
	input  wire logic [10:0] core_code,
	output logic [4:0]       active_channel,
	output logic [1:0]       active_reference,
	output logic             differential,
	output logic             gain_20x,
	output logic [4:0]       conv_cycles,
	output logic             refout_o,
	output logic             refout_oe,
	output logic             refout_2v56
);

	// The signed difference code must hold sign plus ten bits.
	if (CODE_W != 11) begin : g_chk
		$error("arsel_top: CODE_W must be 11");
	end

	// Decode of the reference source from two bits and the enable.
	function automatic arsel_pkg::arsel_ref_t ref_decode(
		input logic [1:0] refs,
		input logic       ext_en
	);
		arsel_pkg::arsel_ref_t r;
		r = arsel_pkg::ARSEL_REF_SUPPLY;
		if (!refs[0]) begin
			r = ext_en ? arsel_pkg::ARSEL_REF_EXTPIN
			           : arsel_pkg::ARSEL_REF_SUPPLY;
		end else if (refs[1]) begin
			r = arsel_pkg::ARSEL_REF_2V56;
		end else begin
			r = arsel_pkg::ARSEL_REF_1V1;
		end
		return r;
	endfunction : ref_decode

	logic [7:0] select_reg;
	logic [2:0] ctrl_reg;
	logic [4:0] act_ch_reg;
	logic [1:0] act_ref_reg;
	logic       busy_reg;
	logic       long_reg;
	logic       done_reg;
	logic [9:0] result_reg;
	logic       pready_reg;
	logic [31:0] prdata_reg;
	logic       pslverr_reg;
	logic [4:0] cycles_reg;
	logic       refo_oe_reg;
	logic       refo_hi_reg;
	logic       gain_reg;
	arsel_pkg::arsel_ref_t act_src_reg;

	logic       wr_en;
	logic       rd_en;
	logic       safe_copy;
	logic [1:0] ref_next;
	logic [9:0] result_next;
	logic [15:0] aligned;
	logic [31:0] rdata_next;
	logic        bad_addr;
	logic        ref_change;

	// Access phase strobes; the slave answers with one wait state.
	assign wr_en = psel & penable & ~pready_reg & pwrite;
	assign rd_en = psel & penable & ~pready_reg & ~pwrite;

	// Selection follows the temporary register while idle or on done.
	assign safe_copy = ~busy_reg | core_done;

	// A copy point that brings in different reference bits.
	assign ref_change = safe_copy & (ref_next != act_ref_reg);

	// Temporary select register, software read and write.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			select_reg <= arsel_pkg::SELECT_RST;
		end else if (wr_en && paddr == arsel_pkg::OFF_SELECT) begin
			select_reg <= pwdata[7:0];
		end
	end

	// Control register: bipolar, external enable, reference output.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_reg <= arsel_pkg::CTRL_RST;
		end else if (wr_en && paddr == arsel_pkg::OFF_CTRL) begin
			ctrl_reg <= pwdata[2:0];
		end
	end

	// Active channel and reference copied only at safe points.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			act_ch_reg  <= 5'h00;
			act_ref_reg <= 2'h0;
			gain_reg    <= 1'b0;
		end else if (safe_copy) begin
			act_ch_reg  <= select_reg[arsel_pkg::SEL_CH_MSB:0];
			gain_reg    <= select_reg[arsel_pkg::SEL_CH_MSB]
			             & select_reg[0];
			act_ref_reg <= select_reg[arsel_pkg::SEL_REF_HI:
			                          arsel_pkg::SEL_REF_LO];
		end
	end

	assign ref_next = select_reg[arsel_pkg::SEL_REF_HI:
	                             arsel_pkg::SEL_REF_LO];

	// Busy from start until the core reports completion.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			busy_reg <= 1'b0;
		end else if (conv_start && !busy_reg) begin
			busy_reg <= 1'b1;
		end else if (core_done) begin
			busy_reg <= 1'b0;
		end
	end

	// A reference change marks the next conversion as long.
	// A start consumes the mark, also one copied in at that very start.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			long_reg <= 1'b0;
		end else if (conv_start && !busy_reg) begin
			long_reg <= 1'b0;
		end else if (ref_change) begin
			long_reg <= 1'b1;
		end
	end

	// Conversion length handed to the core at each start.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cycles_reg <= arsel_pkg::CONV_NORMAL;
		end else if (conv_start && !busy_reg) begin
			cycles_reg <= (long_reg | ref_change) ? arsel_pkg::CONV_LONG
			                       : arsel_pkg::CONV_NORMAL;
		end
	end

	// Format the signed core difference by conversion type.
	// The code never exceeds ten magnitude bits, so no upper clamp is needed.
	always_comb begin
		result_next = core_code[9:0];
		if (!act_ch_reg[4]) begin
			// Single ended: clamp to 0..1023.
			result_next = core_code[10] ? 10'h000
			                            : core_code[9:0];
		end else if (!ctrl_reg[arsel_pkg::CTRL_BIPOLAR]) begin
			// Unipolar: negative difference saturates to zero.
			result_next = core_code[10] ? 10'h000
			                            : core_code[9:0];
		end else begin
			// Bipolar: halve scale, keep sign in bit nine.
			result_next = core_code[10:1];
		end
	end

	// Result capture and done flag in the same cycle.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			result_reg <= 10'h000;
		end else if (core_done) begin
			result_reg <= result_next;
		end
	end

	// Done flag: set wins over write-one-to-clear.
	// A clear in the cycle of completion loses, so no result goes unseen.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			done_reg <= 1'b0;
		end else if (core_done) begin
			done_reg <= 1'b1;
		end else if (wr_en && paddr == arsel_pkg::OFF_STATUS &&
		             pwdata[arsel_pkg::STAT_DONE]) begin
			done_reg <= 1'b0;
		end
	end

	// Alignment follows the left-adjust bit at once.
	assign aligned = select_reg[arsel_pkg::SEL_LADJ]
	               ? {result_reg, 6'h00}
	               : {6'h00, result_reg};

	// Read data and unmapped address decode.
	always_comb begin
		rdata_next = 32'h0000_0000;
		bad_addr   = 1'b0;
		if (paddr == arsel_pkg::OFF_SELECT) begin
			rdata_next[7:0] = select_reg;
		end else if (paddr == arsel_pkg::OFF_RES_LO) begin
			rdata_next[7:0] = aligned[7:0];
		end else if (paddr == arsel_pkg::OFF_RES_HI) begin
			rdata_next[7:0] = aligned[15:8];
		end else if (paddr == arsel_pkg::OFF_CTRL) begin
			rdata_next[2:0] = ctrl_reg;
		end else if (paddr == arsel_pkg::OFF_STATUS) begin
			rdata_next[arsel_pkg::STAT_DONE] = done_reg;
			rdata_next[arsel_pkg::STAT_BUSY] = busy_reg;
			rdata_next[arsel_pkg::STAT_LONG] = long_reg;
		end else if (paddr == arsel_pkg::OFF_CAL) begin
			rdata_next[15:0] = {OFFSET_CAL, GAIN_CAL};
		end else begin
			bad_addr = 1'b1;
		end
	end

	// APB answer registers.
	// Strobes fall once pready is up, so each access acts only once.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= psel & penable & ~pready_reg;
			pslverr_reg <= psel & penable & ~pready_reg & bad_addr;
			if (rd_en) begin
				prdata_reg <= rdata_next;
			end
		end
	end

	// Reference output pin drive from the active selection.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			refo_oe_reg <= 1'b0;
			refo_hi_reg <= 1'b0;
		end else begin
			refo_oe_reg <= converter_on & ctrl_reg[arsel_pkg::CTRL_REF_OUT]
			             & act_ref_reg[0];
			refo_hi_reg <= act_ref_reg[1];
		end
	end

	// Decoded reference source, held in a flop so the port is glitch free.
	// It lags the copy by one cycle, in step with the reference pin drive.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			act_src_reg <= arsel_pkg::ARSEL_REF_SUPPLY;
		end else begin
			act_src_reg <= ref_decode(act_ref_reg,
			               ctrl_reg[arsel_pkg::CTRL_EXT_REF]);
		end
	end

	assign pready           = pready_reg;
	assign prdata           = prdata_reg;
	assign pslverr          = pslverr_reg;
	assign active_channel   = act_ch_reg;
	assign active_reference = act_src_reg;
	assign differential     = act_ch_reg[arsel_pkg::SEL_CH_MSB];
	assign gain_20x         = gain_reg;
	assign conv_cycles      = cycles_reg;
	assign refout_o         = refo_oe_reg;
	assign refout_oe        = refo_oe_reg;
	assign refout_2v56      = refo_hi_reg;

endmodule : arsel_top

`default_nettype wire

// ===== verilog/arsel_pkg.sv
// Package with offsets, field positions, reset values and counts.
package arsel_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFF_SELECT = 8'h00;
	localparam logic [7:0] OFF_RES_LO = 8'h04;
	localparam logic [7:0] OFF_RES_HI = 8'h08;
	localparam logic [7:0] OFF_CTRL   = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_CAL    = 8'h14;

	// Fields of the channel and reference select register.
	localparam int SEL_REF_HI = 7;
	localparam int SEL_REF_LO = 6;
	localparam int SEL_LADJ   = 5;
	localparam int SEL_CH_MSB = 4;

	// Fields of the control register.
	localparam int CTRL_BIPOLAR = 0;
	localparam int CTRL_EXT_REF = 1;
	localparam int CTRL_REF_OUT = 2;

	// Fields of the status register.
	localparam int STAT_DONE = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_LONG = 2;

	// Values after reset.
	localparam logic [7:0] SELECT_RST = 8'h00;
	localparam logic [2:0] CTRL_RST   = 3'h0;

	// Conversion lengths in converter clock cycles.
	localparam logic [4:0] CONV_NORMAL = 5'h0d;
	localparam logic [4:0] CONV_LONG   = 5'h19;

	// Decoded reference source.
	typedef enum logic [1:0] {
		ARSEL_REF_SUPPLY = 2'b00,
		ARSEL_REF_EXTPIN = 2'b01,
		ARSEL_REF_1V1    = 2'b10,
		ARSEL_REF_2V56   = 2'b11
	} arsel_ref_t;

endpackage : arsel_pkg

// ===== verif/arsel_checker.sv
// Port-level checks for the selection and result block.
`timescale 1ns/1ps
`default_nettype none
module arsel_checker (
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        converter_on,
	input wire logic        conv_start,
	input wire logic        core_done,
	input wire logic [4:0]  active_channel,
	input wire logic [1:0]  active_reference,
	input wire logic        differential,
	input wire logic        gain_20x,
	input wire logic [4:0]  conv_cycles,
	input wire logic        refout_o,
	input wire logic        refout_2v56,
	input wire logic        refout_oe
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	logic busy_h;
	// Mirrors the busy state from the start and done pulses.
	always_ff @(posedge clock) begin
		if (sys_rst || core_done) begin
			busy_h <= 1'b0;
		end else if (conv_start) begin
			busy_h <= 1'b1;
		end
	end
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_conv;
		busy_h && !core_done;
	endsequence
	answer_wait_a: assert property (s_access |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	error_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	rdata_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
		else $error("prdata moved");
	gain_pick_a: assert property (gain_20x == (differential
		&& active_channel[0]) && differential == active_channel[4])
		else $error("gain decode wrong");
	sel_freeze_a: assert property (s_conv |=> $stable(active_channel))
		else $error("channel moved while busy");
	cycles_load_a: assert property (!(conv_start && !busy_h)
		|=> $stable(conv_cycles))
		else $error("length moved");
	cycles_set_a: assert property (conv_cycles == arsel_pkg::CONV_NORMAL
		|| conv_cycles == arsel_pkg::CONV_LONG)
		else $error("length value wrong");
	refout_on_a: assert property (refout_oe |-> $past(converter_on))
		else $error("reference driven while off");
	refout_pair_a: assert property (refout_o == refout_oe)
		else $error("reference drive mismatch");
	ref_level_a: assert property (refout_oe |-> active_reference[1]
		&& refout_2v56 == active_reference[0])
		else $error("reference level wrong");
endmodule : arsel_checker
bind arsel_top arsel_checker u_chk (.clock(clock), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .converter_on(converter_on),
	.conv_start(conv_start), .core_done(core_done),
	.active_channel(active_channel), .differential(differential),
	.gain_20x(gain_20x), .conv_cycles(conv_cycles), .refout_o(refout_o),
	.refout_oe(refout_oe), .active_reference(active_reference),
	.refout_2v56(refout_2v56));
`default_nettype wire

// ===== verif/arsel_core_model.sv
// Model of the analog core: counts a conversion, then pulses done.
`timescale 1ns/1ps
`default_nettype none
module arsel_core_model (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        conv_start,
	input  wire logic [7:0]  lat,
	input  wire logic [10:0] code_in,
	output logic             core_done,
	output logic [10:0]      core_code
);
	logic [7:0] cnt_reg;
	// Code is valid only with done; otherwise it toggles so stale use shows.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt_reg   <= 8'h00;
			core_done <= 1'b0;
			core_code <= 11'h000;
		end else begin
			core_done <= (cnt_reg == 8'h01);
			core_code <= (cnt_reg == 8'h01) ? code_in : ~core_code;
			if (cnt_reg != 8'h00) begin
				cnt_reg <= cnt_reg - 8'h01;
			end else if (conv_start) begin
				cnt_reg <= lat;
			end
		end
	end
endmodule : arsel_core_model
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the selection and result block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct {
		logic [7:0]  sel;
		logic [2:0]  ctrl;
		logic [10:0] code;
		logic [15:0] res;
	} arsel_row_t;
	logic        clock;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        converter_on;
	logic        conv_start;
	logic        core_done;
	logic [10:0] core_code;
	logic [4:0]  active_channel;
	logic [1:0]  active_reference;
	logic        differential;
	logic        gain_20x;
	logic [4:0]  conv_cycles;
	logic        refout_o;
	logic        refout_oe;
	logic        refout_2v56;
	logic [7:0]  lat;
	logic [10:0] code_in;
	logic [31:0] rdata;
	logic        rerr;
	int          n_mismatch;
	int          cmp_count;
	arsel_row_t  rows[7] = '{'{8'h00, 3'h0, 11'h3ff, 16'h03ff},
		'{8'h00, 3'h2, 11'h7ff, 16'h0000}, '{8'h50, 3'h4, 11'h400, 16'h0000},
		'{8'hf1, 3'h4, 11'h1ff, 16'h7fc0}, '{8'h10, 3'h1, 11'h400, 16'h0200},
		'{8'h1f, 3'h1, 11'h3fe, 16'h01ff}, '{8'h20, 3'h1, 11'h0ff, 16'h3fc0}};
	logic [31:0] rst_exp[6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'ha55a};
	// Calibration parameters are arbitrary values.
	arsel_top #(.GAIN_CAL(8'h5a), .OFFSET_CAL(8'ha5)) u_dut (.clock(clock),
		.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .converter_on(converter_on),
		.conv_start(conv_start), .core_done(core_done), .core_code(core_code),
		.active_channel(active_channel), .active_reference(active_reference),
		.differential(differential), .gain_20x(gain_20x),
		.conv_cycles(conv_cycles), .refout_o(refout_o), .refout_oe(refout_oe),
		.refout_2v56(refout_2v56));
	arsel_core_model u_core (.clock(clock), .sys_rst(sys_rst),
		.conv_start(conv_start), .lat(lat), .code_in(code_in),
		.core_done(core_done), .core_code(core_code));
	// Free-running converter clock.
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'b1 && i < 40);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			report_and_stop();
		end else begin
			@(posedge clock);
		end
	endtask : apb
	task automatic start(input logic [10:0] c, input logic [7:0] l);
		code_in <= c;
		lat <= l;
		conv_start <= 1'b1;
		@(posedge clock);
		conv_start <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : start
	task automatic wait_done();
		int i;
		for (i = 0; i < 60 && core_done !== 1'b1; i++)
			@(posedge clock);
		if (core_done !== 1'b1) begin
			n_mismatch++;
			report_and_stop();
		end else begin
			repeat (2) @(posedge clock);
		end
	endtask : wait_done
	// Main sequence: reset values, table rows, then the awkward cases.
	initial begin
		{psel, penable, pwrite, paddr, pwdata, conv_start} = '0;
		{sys_rst, converter_on, lat, code_in, n_mismatch, cmp_count} = '0;
		sys_rst = 1'b1;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		chk(32'(conv_cycles), 32'(arsel_pkg::CONV_NORMAL));
		for (int k = 0; k < 6; k++) begin
			apb(1'b0, 8'(4 * k), 32'h0);
			chk(rdata, rst_exp[k]);
		end
		apb(1'b0, 8'h18, 32'h0);
		chk(32'(rerr), 32'h1);
		chk(rdata, 32'h0);
		$display("reset test done");
		converter_on <= 1'b1;
		foreach (rows[k]) begin
			apb(1'b1, arsel_pkg::OFF_CTRL, 32'(rows[k].ctrl));
			apb(1'b1, arsel_pkg::OFF_SELECT, 32'(rows[k].sel));
			start(rows[k].code, 8'h04);
			wait_done();
			apb(1'b0, arsel_pkg::OFF_RES_LO, 32'h0);
			chk(rdata, 32'(rows[k].res[7:0]));
			apb(1'b0, arsel_pkg::OFF_RES_HI, 32'h0);
			chk(rdata, 32'(rows[k].res[15:8]));
			apb(1'b0, arsel_pkg::OFF_STATUS, 32'h0);
			chk(32'(rdata[0]), 32'h1);
			apb(1'b1, arsel_pkg::OFF_STATUS, 32'h1);
			chk(32'(gain_20x), 32'(rows[k].sel[4] & rows[k].sel[0]));
			chk(32'(active_reference), 32'(rows[k].sel[6] ? {1'b1,
				rows[k].sel[7]} : {1'b0, rows[k].ctrl[1]}));
			chk(32'({refout_oe, refout_2v56 & refout_oe}),
				32'({2{rows[k].ctrl[2] & rows[k].sel[6]}} &
				{1'b1, rows[k].sel[7]}));
			$display("row %0d done", k);
		end
		apb(1'b0, arsel_pkg::OFF_STATUS, 32'h0);
		chk(32'(rdata[0]), 32'h0);
		apb(1'b1, arsel_pkg::OFF_SELECT, 32'h00);
		apb(1'b0, arsel_pkg::OFF_RES_LO, 32'h0);
		chk(rdata, 32'hff);
		apb(1'b1, arsel_pkg::OFF_CTRL, 32'h0);
		start(11'h001, 8'h14);
		apb(1'b1, arsel_pkg::OFF_SELECT, 32'h5f);
		start(11'h002, 8'h03);
		chk(32'({active_channel, active_reference}), 32'h0);
		wait_done();
		chk(32'({active_channel, active_reference}), 32'h7e);
		apb(1'b0, arsel_pkg::OFF_STATUS, 32'h0);
		chk(32'(rdata[2]), 32'h1);
		start(11'h003, 8'h03);
		chk(32'(conv_cycles), 32'(arsel_pkg::CONV_LONG));
		wait_done();
		start(11'h004, 8'h03);
		chk(32'(conv_cycles), 32'(arsel_pkg::CONV_NORMAL));
		wait_done();
		apb(1'b1, arsel_pkg::OFF_CTRL, 32'h4);
		chk(32'(refout_oe), 32'h1);
		converter_on <= 1'b0;
		repeat (3) @(posedge clock);
		chk(32'(refout_oe), 32'h0);
		$display("deferred selection test done");
		apb(1'b1, arsel_pkg::OFF_SELECT, 32'h4b);
		start(11'h144, 8'h03);
		wait_done();
		chk(32'({active_channel, active_reference}), 32'h2e);
		apb(1'b0, arsel_pkg::OFF_RES_LO, 32'h0);
		chk(rdata, 32'h44);
		apb(1'b0, arsel_pkg::OFF_RES_HI, 32'h0);
		chk(rdata, 32'h01);
		$display("sensor selection test done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		chk(32'(active_channel), 32'h0);
		apb(1'b0, arsel_pkg::OFF_SELECT, 32'h0);
		chk(rdata, 32'h0);
		apb(1'b0, arsel_pkg::OFF_CTRL, 32'h0);
		chk(rdata, 32'h0);
		$display("mid-run reset test done");
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
